/* src/tcs_pkg.sv */
// package: register map, field positions, reset values and encodings of the timer channel
package tcs_pkg;
   // ==========================================================
   // bus geometry
   localparam int unsigned ADDR_W = 8;                  // byte address width
   localparam int unsigned DATA_W = 32;                 // bus data width
   localparam int unsigned CNT_W  = 16;                 // timer counter width
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_SC    = 8'h00;            // channel_status_control
   localparam logic [7:0] OFS_VAL   = 8'h04;            // channel_value_pair
   localparam logic [7:0] OFS_CFG   = 8'h08;            // timer configuration
   localparam logic [7:0] OFS_ISTAT = 8'h0C;            // sticky interrupt status
   localparam logic [7:0] OFS_IMASK = 8'h10;            // interrupt mask
   // ==========================================================
   // channel_status_control field positions
   localparam int unsigned SC_FLAG  = 7;                // channel_event_flag
   localparam int unsigned SC_IE    = 6;                // channel_irq_enable
   localparam int unsigned SC_MSB   = 5;                // mode_select_b
   localparam int unsigned SC_MSA   = 4;                // mode_select_a
   localparam int unsigned SC_ELS_H = 3;                // edge_level_select high bit
   localparam int unsigned SC_ELS_L = 2;                // edge_level_select low bit
   // configuration and interrupt fields
   localparam int unsigned CFG_CAS  = 0;                // center_aligned_select
   localparam int unsigned IRQ_N    = 2;                // number of sticky events
   localparam int unsigned IRQ_EVT  = 0;                // any channel event
   localparam int unsigned IRQ_CAP  = 1;                // capture taken
   // ==========================================================
   // reset values
   localparam logic [7:0]       SC_RST    = 8'h00;
   localparam logic [CNT_W-1:0] VAL_RST   = 16'h0000;
   localparam logic [IRQ_N-1:0] IRQ_RST   = 2'h0;
   // ==========================================================
   // edge_level_select encodings
   localparam logic [1:0] ELS_OFF  = 2'h0;              // pin released to gpio
   localparam logic [1:0] ELS_RISE = 2'h1;              // capture rising / toggle
   localparam logic [1:0] ELS_FALL = 2'h2;              // capture falling / clear
   localparam logic [1:0] ELS_BOTH = 2'h3;              // capture any / set
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // channel modes, gray coded along capture, compare, edge pwm, center pwm
   typedef enum logic [1:0] {
      TCS_CAPTURE = 2'b00,
      TCS_COMPARE = 2'b01,
      TCS_EPWM    = 2'b11,
      TCS_CPWM    = 2'b10
   } tcs_mode_t;
endpackage

/* src/tcs_axil_slave.sv */
// module: axi4-lite slave front end that turns bus transfers into register strobes
`timescale 1ns/1ps
module tcs_axil_slave
   import tcs_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [DATA_W-1:0] s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   input  wire logic [ADDR_W-1:0] s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [DATA_W-1:0]      s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   output logic                   wr_en,
   output logic [ADDR_W-1:0]      wr_addr,
   output logic [DATA_W-1:0]      wr_data,
   output logic [3:0]             wr_strb,
   input  wire logic              wr_err,
   output logic                   rd_en,
   output logic [ADDR_W-1:0]      rd_addr,
   input  wire logic [DATA_W-1:0] rd_data,
   input  wire logic              rd_err
);
   logic aw_got;                                        // address held
   logic w_got;                                         // data held
   logic ar_got;                                        // read address held

   // one strobe per transfer: it drops as soon as the answer is raised
   assign wr_en = aw_got & w_got & ~s_bvalid;
   assign rd_en = ar_got & ~s_rvalid;

   // ==========================================================
   // write address and data, taken in either order
   always_ff @(posedge clk) begin
      if (!nrst) begin
         aw_got    <= 1'b0;
         w_got     <= 1'b0;
         s_awready <= 1'b1;
         s_wready  <= 1'b1;
         wr_addr   <= '0;
         wr_data   <= '0;
         wr_strb   <= '0;
      end else if (s_bvalid && s_bready) begin
         aw_got    <= 1'b0;
         w_got     <= 1'b0;
         s_awready <= 1'b1;
         s_wready  <= 1'b1;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_got    <= 1'b1;
            s_awready <= 1'b0;
            wr_addr   <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_got    <= 1'b1;
            s_wready <= 1'b0;
            wr_data  <= s_wdata;
            wr_strb  <= s_wstrb;
         end
      end
   end

   // write response, one cycle after both halves are held
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_bvalid <= 1'b0;
         s_bresp  <= RESP_OKAY;
      end else if (wr_en) begin
         s_bvalid <= 1'b1;
         s_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // read channel: data is sampled on the strobe so read side effects happen once
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ar_got    <= 1'b0;
         s_arready <= 1'b1;
         rd_addr   <= '0;
         s_rvalid  <= 1'b0;
         s_rdata   <= '0;
         s_rresp   <= RESP_OKAY;
      end else begin
         if (s_arvalid && s_arready) begin
            ar_got    <= 1'b1;
            s_arready <= 1'b0;
            rd_addr   <= s_araddr;
         end
         if (rd_en) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rd_data;
            s_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
         end else if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            ar_got    <= 1'b0;
            s_arready <= 1'b1;
         end
      end
   end
endmodule // tcs_axil_slave

/* src/tcs_channel.sv */
// module: one timer channel with status/control, value register, pin logic and interrupt
`timescale 1ns/1ps
module tcs_channel
   import tcs_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [DATA_W-1:0] s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   input  wire logic [ADDR_W-1:0] s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [DATA_W-1:0]      s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   // shared timer counter
   input  wire logic [CNT_W-1:0]  count_value,
   input  wire logic              count_update,
   // channel pin
   input  wire logic              pin_in,
   output logic                   pin_out,
   output logic                   pin_oe,
   // interrupt request
   output logic                   irq
);
   // ==========================================================
   // register strobes from the bus front end
   logic              wr_en;                            // write strobe
   logic [ADDR_W-1:0] wr_addr;                          // write byte address
   logic [DATA_W-1:0] wr_data;                          // write data
   logic [3:0]        wr_strb;                          // write byte enables
   logic              wr_err;                           // write hit no register
   logic              rd_en;                            // read strobe
   logic [ADDR_W-1:0] rd_addr;                          // read byte address
   logic [DATA_W-1:0] rd_data;                          // read data to sample
   logic              rd_err;                           // read hit no register

   // ==========================================================
   // register state
   logic              event_flag;                       // channel_event_flag
   logic              irq_enable;                       // channel_irq_enable
   logic              mode_select_b;                    // mode_select_b
   logic              mode_select_a;                    // mode_select_a
   logic [1:0]        edge_level_select;                // edge_level_select
   logic              center_aligned_select;            // center_aligned_select
   logic [CNT_W-1:0]  value_pair;                       // channel_value_pair
   logic [IRQ_N-1:0]  irq_status;                       // sticky events
   logic [IRQ_N-1:0]  irq_mask;                         // mask for irq_status
   logic              clear_armed;                      // flag seen set by a read
   logic              pin_prev;                         // pin sample one cycle ago

   // ==========================================================
   // decoded strobes and events
   tcs_mode_t         mode;                             // current channel mode
   logic              wr_sc;                            // byte 0 write to sc
   logic              wr_val_lo;                        // value low byte write
   logic              wr_val_hi;                        // value high byte write
   logic              rd_sc;                            // read of sc
   logic              rd_istat;                         // read of sticky status
   logic              rise;                             // pin rising edge
   logic              fall;                             // pin falling edge
   logic              capture;                          // active capture edge
   logic              match;                            // counter met value
   logic              chan_event;                       // any flag-setting event
   logic              next_flag;                        // flag after this edge
   logic [IRQ_N-1:0]  irq_events;                       // events this cycle
   logic              pwm_active;                       // duty phase of pwm
   logic [7:0]        sc_read;                          // sc as read back

   // ==========================================================
   // bus front end
   tcs_axil_slave u_axil (
      .clk       (clk),
      .nrst      (nrst),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr_en     (wr_en),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .wr_strb   (wr_strb),
      .wr_err    (wr_err),
      .rd_en     (rd_en),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data),
      .rd_err    (rd_err)
   );

   // ==========================================================
   // mode decode: center pwm overrides the per-channel selects
   always_comb begin
      if (center_aligned_select) begin
         mode = TCS_CPWM;
      end else if (mode_select_b) begin
         mode = TCS_EPWM;
      end else if (mode_select_a) begin
         mode = TCS_COMPARE;
      end else begin
         mode = TCS_CAPTURE;
      end
   end

   // ==========================================================
   // address decode for the strobes
   assign wr_sc     = wr_en & (wr_addr == OFS_SC) & wr_strb[0];
   assign wr_val_lo = wr_en & (wr_addr == OFS_VAL) & wr_strb[0];
   assign wr_val_hi = wr_en & (wr_addr == OFS_VAL) & wr_strb[1];
   assign rd_sc     = rd_en & (rd_addr == OFS_SC);
   assign rd_istat  = rd_en & (rd_addr == OFS_ISTAT);

   // ==========================================================
   // event detection; pin is sampled as synchronous to clk
   assign rise = pin_in & ~pin_prev;
   assign fall = ~pin_in & pin_prev;

   // capture only in capture mode; els off there leaves the channel idle
   always_comb begin
      capture = 1'b0;
      if (mode == TCS_CAPTURE) begin
         case (edge_level_select)
            ELS_RISE: capture = rise;
            ELS_FALL: capture = fall;
            ELS_BOTH: capture = rise | fall;
            default:  capture = 1'b0;
         endcase
      end
   end

   // a match counts once per counter step, so a stalled counter does not refire
   assign match = count_update & (count_value == value_pair) &
                  (mode != TCS_CAPTURE);

   assign chan_event = capture | match;

   // pin sample register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= pin_in;
      end
   end

   // ==========================================================
   // flag clear sequence: a read that sees the flag set arms the clear,
   // a later write of zero fires it; any event disarms and sets the flag
   always_comb begin
      next_flag = event_flag;
      if (chan_event) begin
         next_flag = 1'b1;
      end else if (wr_sc && clear_armed && !wr_data[SC_FLAG]) begin
         next_flag = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         event_flag  <= 1'b0;
         clear_armed <= 1'b0;
      end else begin
         event_flag <= next_flag;
         if (chan_event) begin
            clear_armed <= 1'b0;
         end else if (rd_sc && event_flag) begin
            clear_armed <= 1'b1;
         end else if (wr_sc && !wr_data[SC_FLAG]) begin
            clear_armed <= 1'b0;
         end
      end
   end

   // ==========================================================
   // control bits of the status/control register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_enable        <= SC_RST[SC_IE];
         mode_select_b     <= SC_RST[SC_MSB];
         mode_select_a     <= SC_RST[SC_MSA];
         edge_level_select <= SC_RST[SC_ELS_H:SC_ELS_L];
      end else if (wr_sc) begin
         irq_enable        <= wr_data[SC_IE];
         mode_select_b     <= wr_data[SC_MSB];
         mode_select_a     <= wr_data[SC_MSA];
         edge_level_select <= wr_data[SC_ELS_H:SC_ELS_L];
      end
   end

   // timer configuration; shared by all channels in a full timer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         center_aligned_select <= 1'b0;
      end else if (wr_en && wr_addr == OFS_CFG && wr_strb[0]) begin
         center_aligned_select <= wr_data[CFG_CAS];
      end
   end

   // ==========================================================
   // value register: capture wins over a software write in the same cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         value_pair <= VAL_RST;
      end else if (capture) begin
         value_pair <= count_value;
      end else begin
         if (wr_val_lo) begin
            value_pair[7:0] <= wr_data[7:0];
         end
         if (wr_val_hi) begin
            value_pair[15:8] <= wr_data[15:8];
         end
      end
   end

   // ==========================================================
   // pin driver: pwm high-true when els high bit set, low-true otherwise
   assign pwm_active = count_value < value_pair;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         // els zero hands the pin back to general purpose io
         pin_oe <= (edge_level_select != ELS_OFF) &&
                   (mode != TCS_CAPTURE);
         case (mode)
            TCS_COMPARE: begin
               if (match) begin
                  case (edge_level_select)
                     ELS_RISE: pin_out <= ~pin_out;
                     ELS_FALL: pin_out <= 1'b0;
                     ELS_BOTH: pin_out <= 1'b1;
                     default:  pin_out <= pin_out;
                  endcase
               end
            end
            TCS_EPWM, TCS_CPWM: begin
               // the output follows the counter, so the first period is already right
               pin_out <= edge_level_select[1] ? pwm_active : ~pwm_active;
            end
            default: begin
               pin_out <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // sticky status, cleared by its read; an event in that cycle survives
   assign irq_events = {capture, chan_event};

   genvar gi;
   generate
      for (gi = 0; gi < IRQ_N; gi = gi + 1) begin : g_sticky
         always_ff @(posedge clk) begin
            if (!nrst) begin
               irq_status[gi] <= IRQ_RST[gi];
            end else if (irq_events[gi]) begin
               irq_status[gi] <= 1'b1;
            end else if (rd_istat) begin
               irq_status[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // mask register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_mask <= IRQ_RST;
      end else if (wr_en && wr_addr == OFS_IMASK && wr_strb[0]) begin
         irq_mask <= wr_data[IRQ_N-1:0];
      end
   end

   // ==========================================================
   // interrupt output, registered: one cycle behind a flag event, two behind a sticky status event
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= (next_flag & irq_enable) |
                (|(irq_status & irq_mask));
      end
   end

   // ==========================================================
   // read mux; reserved bits read zero, unmapped addresses answer slverr
   assign sc_read = {event_flag, irq_enable, mode_select_b, mode_select_a,
                     edge_level_select, 2'b00};

   always_comb begin
      rd_data = '0;
      rd_err  = 1'b0;
      case (rd_addr)
         OFS_SC:    rd_data[7:0]       = sc_read;
         OFS_VAL:   rd_data[CNT_W-1:0] = value_pair;
         OFS_CFG:   rd_data[CFG_CAS]   = center_aligned_select;
         OFS_ISTAT: rd_data[IRQ_N-1:0] = irq_status;
         OFS_IMASK: rd_data[IRQ_N-1:0] = irq_mask;
         default:   rd_err             = 1'b1;
      endcase
   end

   // writes that hit no register answer slverr and change nothing
   always_comb begin
      case (wr_addr)
         OFS_SC, OFS_VAL, OFS_CFG, OFS_ISTAT, OFS_IMASK: wr_err = 1'b0;
         default: wr_err = 1'b1;
      endcase
   end
endmodule // tcs_channel

/* verif/tcs_chk.sv */
// checker: bus timing, reserved read bits and reset state at the channel ports
`timescale 1ns/1ps
module tcs_chk
   import tcs_pkg::*;
(
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              s_awvalid,
   input wire logic              s_awready,
   input wire logic              s_wvalid,
   input wire logic              s_wready,
   input wire logic              s_bvalid,
   input wire logic              s_bready,
   input wire logic [ADDR_W-1:0] s_araddr,
   input wire logic              s_arvalid,
   input wire logic              s_arready,
   input wire logic              s_rvalid,
   input wire logic              s_rready,
   input wire logic [DATA_W-1:0] s_rdata,
   input wire logic [1:0]        s_rresp,
   input wire logic              pin_oe,
   input wire logic              irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [ADDR_W-1:0] rd_addr_q;  // address of the read in flight
   // remember the read address so the answer can be judged by register
   always_ff @(posedge clk) begin
      if (s_arvalid && s_arready) rd_addr_q <= s_araddr;
   end
   // an answer stays low one edge, then rises
   sequence late_rise(s);
      !s ##1 s;
   endsequence
   wr_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready
      |=> late_rise(s_bvalid)) else $error("write answer not on time");
   rd_answer_a: assert property (s_arvalid && s_arready |=> late_rise(s_rvalid))
      else $error("read answer not on time");
   wr_busy_a: assert property (s_awvalid && s_awready |=> !s_awready && !s_wready)
      else $error("write accepted twice");
   b_release_a: assert property (s_bvalid && s_bready |=> !s_bvalid && s_awready)
      else $error("write answer not released");
   r_release_a: assert property (s_rvalid && s_rready |=> !s_rvalid && s_arready)
      else $error("read answer not released");
   sc_bits_a: assert property (s_rvalid && rd_addr_q == OFS_SC |-> s_rresp == RESP_OKAY
      && s_rdata[31:8] == 24'h00_0000 && s_rdata[1:0] == 2'h0) else $error("sc read bits");
   unmapped_a: assert property (s_rvalid && rd_addr_q > OFS_IMASK
      |-> s_rresp == RESP_SLVERR && s_rdata == '0) else $error("unmapped read");
   reset_idle_a: assert property (@(posedge clk) disable iff (1'b0) !nrst
      |=> !irq && !pin_oe && !s_bvalid && !s_rvalid) else $error("reset state");
endmodule // tcs_chk

/* verif/tcs_pin_model.sv */
// partner: outside source on the channel pin
`timescale 1ns/1ps
module tcs_pin_model (
   input  wire logic ext_level,  // level the outside source applies
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output logic      pin_in
);
   // while the channel drives, the pin reads back its own level
   assign pin_in = pin_oe ? pin_out : ext_level;
endmodule // tcs_pin_model

/* verif/tb_timer_channel_status_control.sv */
// testbench: capture, flag clearing, compare and pwm of the timer channel
`timescale 1ns/1ps
module tb_timer_channel_status_control
   import tcs_pkg::*;
;
   logic              clk = 1'b0, nrst = 1'b0, ext_level = 1'b0, count_update = 1'b0;
   logic              s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
   logic              s_arvalid = 1'b0, s_rready = 1'b0;
   logic [ADDR_W-1:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [DATA_W-1:0] s_wdata = '0, s_rdata, rd_q;
   logic [3:0]        s_wstrb = 4'hf;
   logic [CNT_W-1:0]  count_value = 16'h0000;
   logic              s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic              pin_in, pin_out, pin_oe, irq;
   logic [1:0]        s_bresp, s_rresp, rs_q, bs_q;
   int                failures = 0, checked = 0;
   always #5 clk = ~clk;
   tcs_channel dut (.*);
   tcs_pin_model u_pin (.*);
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // write: both channels offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_awaddr <= a; s_wdata <= d; s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      bs_q = s_bresp;
      s_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      rd_q = s_rdata; rs_q = s_rresp; s_rready <= 1'b0;
   endtask
   task automatic scx(input logic [7:0] e);
      rd(OFS_SC); chk("sc", {8'h00, e}, rd_q[15:0]);
   endtask
   // one counter step with a new value
   task automatic hit(input logic [15:0] c);
      @(posedge clk) count_value <= c; count_update <= 1'b1;
      @(posedge clk) count_update <= 1'b0;
   endtask
   task automatic pulse_pin;  // falling then rising edge on the pin
      @(posedge clk) ext_level <= 1'b0;
      @(posedge clk) ext_level <= 1'b1;
   endtask
   task automatic t_reset;
      scx(8'h00);
      wr(OFS_SC, 32'h0000_0040); scx(8'h40);
      chk("bresp", 16'(RESP_OKAY), 16'(bs_q));
   endtask
   task automatic t_capture;
      wr(OFS_SC, 32'h0000_0044); @(posedge clk) count_value <= 16'h1234;
      pulse_pin; scx(8'hC4);
      rd(OFS_VAL); chk("value", 16'h1234, rd_q[15:0]);
      chk("irq", 16'h0001, 16'(irq));
   endtask
   task automatic t_clear;  // armed by the last sc read on entry
      pulse_pin; wr(OFS_SC, 32'h0000_0044); scx(8'hC4);
      wr(OFS_SC, 32'h0000_00C4); scx(8'hC4);
      wr(OFS_SC, 32'h0000_0044); scx(8'h44);
      chk("irq", 16'h0000, 16'(irq));
      wr(OFS_SC, 32'h0000_0048); @(posedge clk) ext_level <= 1'b0;
      scx(8'hC8);
   endtask
   task automatic t_compare;  // toggle on match, interrupt through the mask only
      wr(OFS_VAL, 32'h0000_0050); wr(OFS_IMASK, 32'h0000_0001);
      wr(OFS_SC, 32'h0000_0014); rd(OFS_ISTAT);
      chk("istat", 16'h0003, rd_q[15:0]);
      chk("oe", 16'h0001, 16'(pin_oe));
      hit(16'h0050); scx(8'h94);
      chk("pin", 16'h0001, 16'(pin_out));
      chk("irq", 16'h0001, 16'(irq));
      rd(OFS_ISTAT); chk("istat", 16'h0001, rd_q[15:0]);
      @(posedge clk) chk("irq", 16'h0000, 16'(irq));
      wr(OFS_SC, 32'h0000_0018); hit(16'h0050);
      @(posedge clk) chk("pin", 16'h0000, 16'(pin_out));
      wr(OFS_SC, 32'h0000_001C); hit(16'h0050);
      @(posedge clk) chk("pin", 16'h0001, 16'(pin_out));
      wr(OFS_SC, 32'h0000_0010); @(posedge clk) chk("oe", 16'h0000, 16'(pin_oe));
   endtask
   task automatic t_pwm;
      wr(OFS_SC, 32'h0000_0028); hit(16'h0050); scx(8'hA8);
      hit(16'h0010); repeat (2) @(posedge clk);
      chk("pin", 16'h0001, 16'(pin_out));
      wr(OFS_SC, 32'h0000_0024); repeat (2) @(posedge clk);
      chk("pin", 16'h0000, 16'(pin_out));
      wr(OFS_CFG, 32'h0000_0001); wr(OFS_SC, 32'h0000_0028);
      hit(16'h0050); scx(8'hA8);
      rd(8'h20); chk("rresp", 16'(RESP_SLVERR), 16'(rs_q));
      wr(8'h20, 32'h0000_0001); chk("bresp", 16'(RESP_SLVERR), 16'(bs_q));
   endtask
   task automatic stop_test;
      if (failures == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset; t_capture; t_clear; t_compare; t_pwm;
      stop_test;
   end
   // watchdog far beyond the fewer than two hundred cycles the run needs
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      stop_test;
   end
endmodule // tb_timer_channel_status_control
bind tcs_channel tcs_chk u_chk (.*);
